// ---- rtl/temp_monitor_cfg.svh ----
// Register map, reset values and field positions of the monitor.
// Assumes 8-bit register addresses delivered by the bus engine.
`ifndef TEMP_MONITOR_CFG_SVH
`define TEMP_MONITOR_CFG_SVH
// -----------------------------------------------------------
// Read addresses
// -----------------------------------------------------------
`define RD_LOCAL    8'h00
`define RD_REM_HI   8'h01
`define RD_STATUS   8'h02
`define RD_CFG      8'h03
`define RD_RATE     8'h04
`define RD_LHL      8'h05
`define RD_LLL      8'h06
`define RD_RHLH     8'h07
`define RD_RLLH     8'h08
`define RD_REM_LO   8'h10
`define RD_MAKER    8'hFE
`define RD_REV      8'hFF
// -----------------------------------------------------------
// Write addresses
// -----------------------------------------------------------
`define WR_CFG      8'h09
`define WR_RATE     8'h0A
`define WR_LHL      8'h0B
`define WR_LLL      8'h0C
`define WR_RHLH     8'h0D
`define WR_RLLH     8'h0E
`define WR_ONESHOT  8'h0F
// -----------------------------------------------------------
// Shared read and write addresses
// -----------------------------------------------------------
`define RW_OFFH     8'h11
`define RW_OFFL     8'h12
`define RW_RHLL     8'h13
`define RW_RLLL     8'h14
`define RW_RCL      8'h19
`define RW_LCL      8'h20
`define RW_HYST     8'h21
`define RW_CONSEC   8'h22
// -----------------------------------------------------------
// Reset values
// -----------------------------------------------------------
`define RST_ZERO    8'h00
`define RST_LIMIT   8'h55
`define RST_RATE    4'h8
`define RST_HYST    8'h0A
`define RST_CONSEC  8'h01
`define RST_PTR     8'h00
// -----------------------------------------------------------
// Fields
// -----------------------------------------------------------
`define CFG_MASK_BIT   7
`define CFG_STBY_BIT   6
`define CFG_PIN_BIT    5
`define CFG_RANGE_BIT  2
`define CFG_WMASK      8'hE4
`define OFFL_WMASK     8'hC0
`define CONSEC_TMO_BIT 7
`define CONSEC_CODE2   3'h1
`define CONSEC_CODE3   3'h3
`define CONSEC_CODE4   3'h7
`define FILT_ONE       3'h1
`define FILT_TWO       3'h2
`define FILT_THREE     3'h3
`define FILT_MAX       3'h4
`define REMOTE_MAX     10'h3FF
`endif

// ---- rtl/temp_monitor_pkg.sv ----
// Types shared by the monitor's register logic.
// Assumes the constants header for all numeric values.
package temp_monitor_pkg;
    typedef enum logic {PIN_ALARM, PIN_SECOND} pinMode_t;
    typedef logic [7:0] regByte_t;
    typedef logic [9:0] remoteTemp_t;
endpackage

// ---- rtl/temp_monitor_status_alarm_regs.sv ----
// Status, alarm, comparator and register map of the temperature monitor.
// Assumes a bus engine giving pointer, write and read strobes, and an ADC
// giving a one-cycle done pulse with raw readings.
`timescale 1ns/100ps
`include "temp_monitor_cfg.svh"

module temp_monitor_status_alarm_regs
#(
    parameter temp_monitor_pkg::regByte_t MAKER_CODE = 8'h5A,
    parameter temp_monitor_pkg::regByte_t REV_CODE   = 8'h3C
)
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Register access
    input  wire logic       ptrWrite,
    input  wire logic [7:0] ptrData,
    input  wire logic       regWrite,
    input  wire logic [7:0] regData,
    input  wire logic       regRead,
    output logic      [7:0] readData,
    // Alert response
    input  wire logic       araRead,
    // Converter results
    input  wire logic       adcBusy,
    input  wire logic       convDone,
    input  wire logic [7:0] localRaw,
    input  wire logic [9:0] remoteRaw,
    input  wire logic       remoteOpen,
    // Converter control and bus timeout enable
    output logic            standby,
    output logic            oneShot,
    output logic            rangeExtended,
    output logic      [3:0] conversionRate,
    output logic            busTimeoutEn,
    // Pins
    output logic            overtempComparatorN,
    output logic            multiPinN
);

    // Identity values are arbitrary.

    // -----------------------------------------------------------
    // Storage
    // -----------------------------------------------------------
    logic [7:0] pointer;
    logic [7:0] configuration;
    logic [7:0] localHighLimit;
    logic [7:0] localLowLimit;
    logic [7:0] remoteHighLimitHigh;
    logic [7:0] remoteLowLimitHigh;
    logic [7:0] remoteHighLimitLow;
    logic [7:0] remoteLowLimitLow;
    logic [7:0] remoteOffsetHigh;
    logic [7:0] remoteOffsetLow;
    logic [7:0] remoteComparatorLimit;
    logic [7:0] localComparatorLimit;
    logic [7:0] comparatorHysteresis;
    logic [7:0] consecutiveFaultCount;
    logic [7:0] localVal;
    logic [9:0] remoteVal;
    logic       openNow;
    logic       evalPulse;
    logic [2:0] filterRun;
    logic [3:0] limitFlag;
    logic       openFlag;
    logic       remoteComparatorFlag;
    logic       localComparatorFlag;
    logic       alarmLatch;

    // -----------------------------------------------------------
    // Decode
    // -----------------------------------------------------------
    temp_monitor_pkg::pinMode_t pinMode;
    logic        alarmOutputMask;
    logic        statusRead;
    logic        wrCfg;
    logic        wrRate;
    logic        wrOneShot;
    logic        wrConsec;
    logic [9:0]  remoteOffset;
    logic [11:0] sumAdj;
    logic [9:0]  remoteAdj;
    logic [9:0]  remoteHighLimit;
    logic [9:0]  remoteLowLimit;
    logic [3:0]  limitCond;
    logic [3:0]  limitSecond;
    logic        outNow;
    logic [2:0]  need;
    logic [2:0]  next_filterRun;
    logic        setLim;
    logic        faultNow;
    logic        anyAlarm;
    logic [7:0]  statusByte;
    logic [7:0]  readMux;

    assign pinMode = configuration[`CFG_PIN_BIT] ? temp_monitor_pkg::PIN_SECOND
                                                 : temp_monitor_pkg::PIN_ALARM;
    assign alarmOutputMask = configuration[`CFG_MASK_BIT];
    assign standby = configuration[`CFG_STBY_BIT];
    assign rangeExtended = configuration[`CFG_RANGE_BIT];
    assign busTimeoutEn = consecutiveFaultCount[`CONSEC_TMO_BIT];

    assign statusRead = regRead && (pointer == `RD_STATUS);
    assign wrCfg = regWrite && (pointer == `WR_CFG);
    assign wrRate = regWrite && (pointer == `WR_RATE);
    assign wrOneShot = regWrite && (pointer == `WR_ONESHOT);
    assign wrConsec = regWrite && (pointer == `RW_CONSEC);

    // -----------------------------------------------------------
    // Remote offset
    // -----------------------------------------------------------
    // ten-bit offset assembly
    assign remoteOffset = {remoteOffsetHigh, remoteOffsetLow[7:6]};
    assign sumAdj = {2'h0, remoteRaw} + {{2{remoteOffset[9]}}, remoteOffset};
    assign remoteAdj = sumAdj[11] ? 10'h000
                     : sumAdj[10] ? `REMOTE_MAX : sumAdj[9:0];

    // -----------------------------------------------------------
    // Limit conditions
    // -----------------------------------------------------------
    assign remoteHighLimit = {remoteHighLimitHigh, remoteHighLimitLow[7:6]};
    assign remoteLowLimit = {remoteLowLimitHigh, remoteLowLimitLow[7:6]};
    assign limitCond[3] = localVal > localHighLimit;
    assign limitCond[2] = localVal <= localLowLimit;
    assign limitCond[1] = remoteVal > remoteHighLimit;
    assign limitCond[0] = remoteVal <= remoteLowLimit;
    assign outNow = |limitCond;
    assign faultNow = outNow | openNow;

    function automatic logic hystNext(input logic cur, input logic [7:0] v,
                                      input logic [7:0] lim, input logic [7:0] h);
        hystNext = (v > lim) | (cur & (({1'b0, v} + {1'b0, h}) > {1'b0, lim}));
    endfunction

    assign limitSecond[3] = hystNext(limitFlag[3], localVal, localHighLimit,
                                     comparatorHysteresis);
    assign limitSecond[2] = limitCond[2];
    assign limitSecond[1] = hystNext(limitFlag[1], remoteVal[9:2],
                                     remoteHighLimitHigh, comparatorHysteresis);
    assign limitSecond[0] = limitCond[0];

    // -----------------------------------------------------------
    // Consecutive filter
    // -----------------------------------------------------------
    // count decode
    assign need = (consecutiveFaultCount[3:1] == `CONSEC_CODE4) ? `FILT_MAX
                : (consecutiveFaultCount[3:1] == `CONSEC_CODE3) ? `FILT_THREE
                : (consecutiveFaultCount[3:1] == `CONSEC_CODE2) ? `FILT_TWO
                : `FILT_ONE;
    assign next_filterRun = !outNow ? 3'h0
                          : (filterRun == `FILT_MAX) ? filterRun
                          : 3'(filterRun + 3'h1);
    assign setLim = evalPulse && (pinMode == temp_monitor_pkg::PIN_ALARM)
                    && (next_filterRun >= need);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            filterRun <= 3'h0;
        else if (evalPulse)
            filterRun <= next_filterRun;
    end

    // -----------------------------------------------------------
    // Measurement capture
    // -----------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            localVal <= `RST_ZERO;
            remoteVal <= 10'h000;
            openNow <= 1'b0;
            evalPulse <= 1'b0;
        end
        else
        begin
            evalPulse <= convDone;
            if (convDone)
            begin
                localVal <= localRaw;
                remoteVal <= remoteAdj;
                openNow <= remoteOpen;
            end
        end
    end

    // -----------------------------------------------------------
    // Limit flags, bits 6 to 3
    // -----------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_lim
            logic next_limitFlag;
            assign next_limitFlag = (pinMode == temp_monitor_pkg::PIN_SECOND)
                ? limitSecond[i]
                : (setLim & limitCond[i])
                  | (limitFlag[i] & ~(statusRead & ~limitCond[i]));
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                    limitFlag[i] <= 1'b0;
                else
                    limitFlag[i] <= next_limitFlag;
            end
        end
    endgenerate

    // -----------------------------------------------------------
    // Open flag, comparator flags, alarm latch
    // -----------------------------------------------------------
    // open sensor set
    logic next_openFlag;
    assign next_openFlag = (evalPulse & openNow)
                         | (openFlag & ~(statusRead & ~openNow));

    logic next_remoteComparatorFlag;
    logic next_localComparatorFlag;
    assign next_remoteComparatorFlag = hystNext(remoteComparatorFlag,
        remoteVal[9:2], remoteComparatorLimit, comparatorHysteresis);
    assign next_localComparatorFlag = hystNext(localComparatorFlag,
        localVal, localComparatorLimit, comparatorHysteresis);

    logic next_alarmLatch;
    assign anyAlarm = (pinMode == temp_monitor_pkg::PIN_ALARM)
                      && ((|limitFlag) | openFlag);
    assign next_alarmLatch = anyAlarm
                           | (alarmLatch & ~(araRead & ~faultNow));

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            openFlag <= 1'b0;
            remoteComparatorFlag <= 1'b0;
            localComparatorFlag <= 1'b0;
            alarmLatch <= 1'b0;
        end
        else
        begin
            openFlag <= next_openFlag;
            remoteComparatorFlag <= next_remoteComparatorFlag;
            localComparatorFlag <= next_localComparatorFlag;
            alarmLatch <= next_alarmLatch;
        end
    end

    // -----------------------------------------------------------
    // Pins
    // -----------------------------------------------------------
    // comparator output
    assign overtempComparatorN = !(remoteComparatorFlag | localComparatorFlag);
    assign multiPinN = (pinMode == temp_monitor_pkg::PIN_SECOND)
                     ? !(limitFlag[3] | limitFlag[1])
                     : !(alarmLatch & !alarmOutputMask);

    // -----------------------------------------------------------
    // Register writes
    // -----------------------------------------------------------
    // no status write decode
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pointer <= `RST_PTR;
            configuration <= `RST_ZERO;
            conversionRate <= `RST_RATE;
            localHighLimit <= `RST_LIMIT;
            localLowLimit <= `RST_ZERO;
            remoteHighLimitHigh <= `RST_LIMIT;
            remoteLowLimitHigh <= `RST_ZERO;
            remoteHighLimitLow <= `RST_ZERO;
            remoteLowLimitLow <= `RST_ZERO;
            remoteOffsetHigh <= `RST_ZERO;
            remoteOffsetLow <= `RST_ZERO;
            remoteComparatorLimit <= `RST_LIMIT;
            localComparatorLimit <= `RST_LIMIT;
            comparatorHysteresis <= `RST_HYST;
            consecutiveFaultCount <= `RST_CONSEC;
        end
        else
        begin
            if (ptrWrite)
                pointer <= ptrData;
            if (wrCfg)
                configuration <= regData & `CFG_WMASK;
            if (wrRate)
                conversionRate <= regData[3:0];
            if (regWrite && pointer == `WR_LHL)
                localHighLimit <= regData;
            if (regWrite && pointer == `WR_LLL)
                localLowLimit <= regData;
            if (regWrite && pointer == `WR_RHLH)
                remoteHighLimitHigh <= regData;
            if (regWrite && pointer == `WR_RLLH)
                remoteLowLimitHigh <= regData;
            if (regWrite && pointer == `RW_RHLL)
                remoteHighLimitLow <= regData & `OFFL_WMASK;
            if (regWrite && pointer == `RW_RLLL)
                remoteLowLimitLow <= regData & `OFFL_WMASK;
            if (regWrite && pointer == `RW_OFFH)
                remoteOffsetHigh <= regData;
            if (regWrite && pointer == `RW_OFFL)
                remoteOffsetLow <= regData & `OFFL_WMASK;
            if (regWrite && pointer == `RW_RCL)
                remoteComparatorLimit <= regData;
            if (regWrite && pointer == `RW_LCL)
                localComparatorLimit <= regData;
            if (regWrite && pointer == `RW_HYST)
                comparatorHysteresis <= regData;
            if (wrConsec)
                consecutiveFaultCount <= regData;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            oneShot <= 1'b0;
        else
            oneShot <= wrOneShot && standby;
    end

    // -----------------------------------------------------------
    // Register reads
    // -----------------------------------------------------------
    // busy in bit 7
    assign statusByte = {adcBusy, limitFlag, openFlag,
                         remoteComparatorFlag, localComparatorFlag};

    always_comb
    begin
        case (pointer)
            `RD_LOCAL:  readMux = localVal;
            `RD_REM_HI: readMux = remoteVal[9:2];
            `RD_STATUS: readMux = statusByte;
            `RD_CFG:    readMux = configuration;
            `RD_RATE:   readMux = {4'h0, conversionRate};
            `RD_LHL:    readMux = localHighLimit;
            `RD_LLL:    readMux = localLowLimit;
            `RD_RHLH:   readMux = remoteHighLimitHigh;
            `RD_RLLH:   readMux = remoteLowLimitHigh;
            `RD_REM_LO: readMux = {remoteVal[1:0], 6'h00};
            `RW_OFFH:   readMux = remoteOffsetHigh;
            `RW_OFFL:   readMux = remoteOffsetLow;
            `RW_RHLL:   readMux = remoteHighLimitLow;
            `RW_RLLL:   readMux = remoteLowLimitLow;
            `RW_RCL:    readMux = remoteComparatorLimit;
            `RW_LCL:    readMux = localComparatorLimit;
            `RW_HYST:   readMux = comparatorHysteresis;
            `RW_CONSEC: readMux = consecutiveFaultCount;
            `RD_MAKER:  readMux = MAKER_CODE;
            `RD_REV:    readMux = REV_CODE;
            default:    readMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            readData <= 8'h00;
        else if (regRead)
            readData <= readMux;
    end

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_busy;
        statusRead |=> readData[7] == $past(adcBusy);
    endproperty
    a_busy: assert property (p_busy) else $error("busy bit wrong");

    property p_overtemp_comparator_n;
        (localVal > localComparatorLimit) || (remoteVal[9:2] > remoteComparatorLimit) |=> !overtempComparatorN;
    endproperty
    a_overtemp_comparator_n: assert property (p_overtemp_comparator_n) else $error("comparator pin wrong");

    property p_hyst;
        localComparatorFlag && ({1'b0, localVal} + {1'b0, comparatorHysteresis}
            <= {1'b0, localComparatorLimit}) |=> !localComparatorFlag;
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis release wrong");

    property p_stwr;
        regWrite && pointer == `RD_STATUS && !regRead && !evalPulse
            && pinMode == temp_monitor_pkg::PIN_ALARM |=> $stable(limitFlag);
    endproperty
    a_stwr: assert property (p_stwr) else $error("status write changed flags");

    property p_shot;
        wrOneShot |=> oneShot == $past(standby);
    endproperty
    a_shot: assert property (p_shot) else $error("one-shot wrong");

    property p_hold;
        alarmLatch && !araRead |=> alarmLatch;
    endproperty
    a_hold: assert property (p_hold) else $error("latch released early");

    property p_latch;
        anyAlarm |=> alarmLatch ##0 (multiPinN == alarmOutputMask || pinMode != temp_monitor_pkg::PIN_ALARM);
    endproperty
    a_latch: assert property (p_latch) else $error("latch not set");

    property p_second;
        pinMode == temp_monitor_pkg::PIN_SECOND && !wrCfg && localVal > localHighLimit |=> !multiPinN;
    endproperty
    a_second: assert property (p_second) else $error("second pin wrong");

    property p_open;
        openFlag && openNow && !convDone |=> openFlag [*2];
    endproperty
    a_open: assert property (p_open) else $error("open flag lost");

    property p_run;
        evalPulse && !outNow |=> filterRun == 3'h0;
    endproperty
    a_run: assert property (p_run) else $error("run not restarted");

    property p_filt;
        evalPulse && limitCond[3] && pinMode == temp_monitor_pkg::PIN_ALARM
            && need == `FILT_ONE |=> limitFlag[3];
    endproperty
    a_filt: assert property (p_filt) else $error("flag not set");

endmodule

// ---- verif/host_model.sv ----
// Host partner model: pointer writes, register writes, reads, alert response.
// Assumes the monitor samples all strobes on the rising edge of clk_sys.
`timescale 1ns/100ps
module host_model
(
    // Clock and read data
    input  wire logic       clk_sys,
    input  wire logic [7:0] readData,
    // Strobes
    output logic            ptrWrite,
    output logic      [7:0] ptrData,
    output logic            regWrite,
    output logic      [7:0] regData,
    output logic            regRead,
    output logic            araRead
);
    initial {ptrWrite, ptrData, regWrite, regData, regRead, araRead} = '0;
    task automatic point(input logic [7:0] a);
        @(posedge clk_sys);
        ptrWrite <= 1'b1;
        ptrData  <= a;
        @(posedge clk_sys);
        ptrWrite <= 1'b0;
        ptrData  <= ~a;
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        point(a);
        regWrite <= 1'b1;
        regData  <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regData  <= ~d;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        point(a);
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(posedge clk_sys);
        d = readData;
    endtask
    task automatic ara();
        @(posedge clk_sys);
        araRead <= 1'b1;
        @(posedge clk_sys);
        araRead <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
endmodule

// ---- verif/test_temp_monitor_status_alarm_regs.sv ----
// Self-checking bench for the monitor's status, alarm and register logic.
// Assumes the host model and a behavioural converter driven here.
`timescale 1ns/100ps
module test_temp_monitor_status_alarm_regs;
    logic       clk_sys, reset, ptrWrite, regWrite, regRead, araRead, adcBusy, convDone, remoteOpen;
    logic       standby, oneShot, rangeExtended, busTimeoutEn, overtempComparatorN, multiPinN;
    logic [7:0] ptrData, regData, readData, localRaw, v;
    logic [9:0] remoteRaw;
    logic [3:0] conversionRate;
    int         mismatches = 0, n_checks = 0, cycles = 0, shots = 0;
    temp_monitor_status_alarm_regs #(.MAKER_CODE(8'h6B)) u_temp_monitor_status_alarm_regs (.clk_sys, .reset,
        .ptrWrite, .ptrData, .regWrite, .regData, .regRead, .readData, .araRead, .adcBusy, .convDone,
        .localRaw, .remoteRaw, .remoteOpen, .standby, .oneShot, .rangeExtended, .conversionRate,
        .busTimeoutEn, .overtempComparatorN, .multiPinN);
    host_model u_host_model (.clk_sys, .readData, .ptrWrite, .ptrData, .regWrite, .regData, .regRead, .araRead);
    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic conv(input logic [7:0] l);
        @(posedge clk_sys);
        convDone  <= 1'b1;
        localRaw  <= l;
        remoteRaw <= 10'h0A0;
        @(posedge clk_sys);
        convDone <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic clearAll();
        conv(8'h20);
        u_host_model.get(8'h02, v);
        u_host_model.get(8'h02, v);
        u_host_model.ara();
    endtask
    task automatic filterTrial(input logic [7:0] code, input int n);
        u_host_model.put(8'h22, code);
        clearAll();
        repeat (n - 1) conv(8'h56);
        check(multiPinN, 8'h01);
        conv(8'h56);
        check(multiPinN, 8'h00);
    endtask
    task automatic conclude();
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic tDefaults();
        logic [7:0] a[6] = '{8'h04, 8'h05, 8'h21, 8'h22, 8'hFE, 8'h30};
        logic [7:0] e[6] = '{8'h08, 8'h55, 8'h0A, 8'h01, 8'h6B, 8'h00};
        for (int i = 0; i < 6; i++)
        begin
            u_host_model.get(a[i], v);
            check(v, e[i]);
        end
        adcBusy <= 1'b1;
        u_host_model.get(8'h02, v);
        check(v, 8'h80);
        adcBusy <= 1'b0;
    endtask
    task automatic tLatch();
        conv(8'h56);
        check(overtempComparatorN, 8'h00);
        check(multiPinN, 8'h00);
        conv(8'h20);
        u_host_model.get(8'h02, v);
        check(v, 8'h40);
        u_host_model.get(8'h02, v);
        check(v, 8'h00);
        check(multiPinN, 8'h00);
        u_host_model.ara();
        check(multiPinN, 8'h01);
        conv(8'h56);
        conv(8'h50);
        check(overtempComparatorN, 8'h00);
        conv(8'h4B);
        check(overtempComparatorN, 8'h01);
        clearAll();
        remoteOpen <= 1'b1;
        conv(8'h20);
        u_host_model.get(8'h02, v);
        check(v, 8'h04);
        check(multiPinN, 8'h00);
        remoteOpen <= 1'b0;
        clearAll();
        u_host_model.get(8'h02, v);
        check(v, 8'h00);
        check(multiPinN, 8'h01);
    endtask
    task automatic tRegs();
        u_host_model.put(8'h11, 8'h01);
        u_host_model.put(8'h12, 8'hFF);
        u_host_model.get(8'h12, v);
        check(v, 8'hC0);
        conv(8'h20);
        u_host_model.get(8'h01, v);
        check(v, 8'h29);
        u_host_model.get(8'h10, v);
        check(v, 8'hC0);
        u_host_model.put(8'h02, 8'hFF);
        u_host_model.get(8'h02, v);
        check(v, 8'h00);
        u_host_model.put(8'h0F, 8'hAA);
        u_host_model.put(8'h09, 8'h44);
        u_host_model.put(8'h0F, 8'hAA);
        repeat (2) @(posedge clk_sys);
        check(shots, 8'h01);
        check(standby, 8'h01);
        check(rangeExtended, 8'h01);
        u_host_model.get(8'h03, v);
        check(v, 8'h44);
        u_host_model.put(8'h09, 8'h00);
        u_host_model.put(8'h0A, 8'h05);
        u_host_model.get(8'h04, v);
        check(v, 8'h05);
        check(conversionRate, 8'h05);
    endtask
    task automatic tFilter();
        u_host_model.put(8'h22, 8'h82);
        @(posedge clk_sys);
        check(busTimeoutEn, 8'h01);
        conv(8'h56);
        conv(8'h20);
        conv(8'h56);
        check(multiPinN, 8'h01);
        conv(8'h56);
        check(multiPinN, 8'h00);
        filterTrial(8'h06, 3);
        filterTrial(8'h0E, 4);
        u_host_model.put(8'h22, 8'h01);
        clearAll();
        u_host_model.put(8'h09, 8'h20);
        u_host_model.put(8'h0C, 8'h30);
        conv(8'h20);
        check(multiPinN, 8'h01);
        conv(8'h56);
        check(multiPinN, 8'h00);
        conv(8'h20);
        check(multiPinN, 8'h01);
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        shots  <= shots + int'(oneShot);
        if (cycles == 3000)
        begin
            mismatches++;
            conclude();
        end
    end
    initial
    begin
        {adcBusy, convDone, remoteOpen, localRaw, remoteRaw} = '0;
        reset = 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        tDefaults();
        tLatch();
        tRegs();
        tFilter();
        conclude();
    end
endmodule
